// ---- src/fpmc_pkg.sv ----
// Constants and types of the front panel menu controller.
package fpmc_pkg;
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned IDLE_S        = 12;
   localparam int unsigned GAIN_IDLE_S   = 30;
   localparam int unsigned PHASE_MS      = 1000;
   localparam int unsigned DEB_MS        = 10;
   localparam int unsigned IDLE_CYC      = IDLE_S * CLK_HZ;
   localparam int unsigned GAIN_IDLE_CYC = GAIN_IDLE_S * CLK_HZ;
   localparam int unsigned PHASE_CYC     = PHASE_MS * (CLK_HZ / 1000);
   localparam int unsigned DEB_CYC       = DEB_MS * (CLK_HZ / 1000);

   // gain held as attenuation in 0.5 dB units
   localparam logic [6:0] GAIN_MIN_HDB = 7'h28;
   localparam logic [6:0] GAIN_MAX_HDB = 7'h64;
   localparam logic [6:0] GAIN_RST_HDB = 7'h3C;
   localparam logic [7:0] STEP_10DB    = 8'h14;
   localparam logic [7:0] STEP_1DB     = 8'h02;
   localparam logic [7:0] STEP_HALF    = 8'h01;
   localparam logic signed [12:0] OFS_LIM = 13'sh07D0;
   localparam logic signed [12:0] OFS_STEP_1000 = 13'sh03E8;
   localparam logic signed [12:0] OFS_STEP_100  = 13'sh0064;
   localparam logic signed [12:0] OFS_STEP_10   = 13'sh000A;
   localparam logic signed [12:0] OFS_STEP_1    = 13'sh0001;

   localparam logic [2:0] CUR_R_GAIN = 3'h3;
   localparam logic [2:0] CUR_R_OFS  = 3'h4;
   localparam logic [2:0] CUR_R_FLAG = 3'h1;

   localparam int SW_MENU  = 0;
   localparam int SW_LEFT  = 1;
   localparam int SW_RIGHT = 2;
   localparam int SW_UP    = 3;
   localparam int SW_DOWN  = 4;
   localparam int SW_N     = 5;

   typedef enum logic [2:0] {ST_LAMP, ST_VER, ST_RUN, ST_EDIT, ST_SAVE}
      fpmc_state_t;
   typedef enum logic [2:0] {MN_GAIN, MN_MUTE, MN_REF, MN_OFS, MN_REMOTE,
      MN_COMM} fpmc_menu_t;
   typedef enum logic [1:0] {REF_INT, REF_EXT, REF_AUTO} fpmc_ref_t;

   typedef struct packed {
      logic [6:0]         gain;
      logic               mute;
      fpmc_ref_t          refsel;
      logic signed [11:0] ofs;
      logic               remote;
      logic               comm;
   } fpmc_set_t;

   localparam int SET_W = $bits(fpmc_set_t);
   localparam fpmc_set_t SET_RST = '{gain: GAIN_RST_HDB, mute: 1'b0,
      refsel: REF_INT, ofs: 12'h000, remote: 1'b0, comm: 1'b0};
endpackage

// ---- src/fpmc_sw_if.sv ----
// Interface between a switch input and its debouncer.
`timescale 1ns/100ps
interface fpmc_sw_if;
   logic raw;
   logic press;
   modport deb (input raw, output press);
   modport usr (output raw, input press);
endinterface

// ---- src/fpmc_debounce.sv ----
// Switch synchroniser and debouncer giving one pulse per press.
`timescale 1ns/100ps
module fpmc_debounce
   import fpmc_pkg::*;
#(
   parameter int unsigned DEB_CYC_P = DEB_CYC
) (
   input  wire logic clk,
   input  wire logic arst_n,
   fpmc_sw_if.deb    sw
);
   localparam int CW = $clog2(DEB_CYC_P + 1);

   if (DEB_CYC_P < 1) begin : g_bad
      $error("fpmc_debounce: DEB_CYC_P must be at least 1");
   end

   logic          s1_q, s2_q, s3_q;
   logic          level_q;
   logic          press_q;
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= sw.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // contact bounce restarts the count, so one press gives one event
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q   <= '0;
         level_q <= 1'b0;
         press_q <= 1'b0;
      end else begin
         press_q <= 1'b0;
         if (s2_q == s3_q && s3_q != level_q) begin
            if (cnt_q == CW'(DEB_CYC_P - 1)) begin
               cnt_q   <= '0;
               level_q <= s3_q;
               press_q <= s3_q;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end else begin
            cnt_q <= '0;
         end
      end
   end

   assign sw.press = press_q;
endmodule

// ---- src/fpmc_top.sv ----
// Front panel menu controller: session, settings and indicators.
`timescale 1ns/100ps
module fpmc_top
   import fpmc_pkg::*;
#(
   parameter int unsigned DEB_CYC_P   = DEB_CYC,
   parameter int unsigned PHASE_CYC_P = PHASE_CYC,
   parameter int unsigned IDLE_CYC_P  = IDLE_CYC,
   parameter int unsigned GIDLE_CYC_P = GAIN_IDLE_CYC,
   parameter logic [15:0] VERSION_P   = 16'h0100 // value is arbitrary
) (
   input  wire logic              MCLK,
   input  wire logic              ARST_N,
   input  wire logic              MENU_SW_N,
   input  wire logic              LEFT_SW_N,
   input  wire logic              RIGHT_SW_N,
   input  wire logic              UP_SW_N,
   input  wire logic              DOWN_SW_N,
   input  wire logic              PLL_UNLOCK,
   input  wire logic              NV_VALID,
   input  wire logic [SET_W-1:0]  NV_RD_DATA,
   output logic                   NV_WE,
   output logic [SET_W-1:0]       NV_WR_DATA,
   output logic [6:0]             GAIN_HDB,
   output logic                   MUTE,
   output logic [1:0]             REF_SEL,
   output logic [11:0]            REF_OFS,
   output logic                   REMOTE,
   output logic                   COMM_SEL,
   output logic                   ALARM,
   output logic                   LED_ALARM,
   output logic                   LED_MUTE,
   output logic                   LED_REMOTE,
   output logic [2:0]             DISP_STATE,
   output logic [2:0]             DISP_MENU,
   output logic [2:0]             DISP_CURSOR,
   output logic                   DISP_SAVE_YES,
   output logic [15:0]            DISP_VERSION
);
   if (PHASE_CYC_P < 1 || IDLE_CYC_P < 1 || GIDLE_CYC_P < 1
       || DEB_CYC_P < 1) begin : g_bad
      $error("fpmc_top: timing parameters must be at least 1");
   end
   default disable iff (!ARST_N);

   fpmc_state_t     state_q;
   fpmc_menu_t      menu_q;
   logic [2:0]      cur_q;
   logic            yes_q;
   logic            load_q;
   logic            nv_we_q;
   fpmc_set_t       live_q, saved_q, live_d, boot;
   logic [31:0]     idle_q, phase_q;
   logic [31:0]     idle_lim;
   logic            tmo, phase_done, in_sess, any_ev, vert_ev;
   logic            m_ev, l_ev, r_ev, u_ev, d_ev;
   logic            on_val, at_r, confirm;
   logic            al1_q, al2_q, al3_q, alarm_q;
   logic [SW_N-1:0] raw_n, press;

   // switch inputs: active low pins, one debouncer each
   fpmc_sw_if sw_if [SW_N] ();
   assign raw_n = {DOWN_SW_N, UP_SW_N, RIGHT_SW_N, LEFT_SW_N, MENU_SW_N};

   for (genvar i = 0; i < SW_N; i++) begin : g_sw
      assign sw_if[i].raw = ~raw_n[i];
      assign press[i]     = sw_if[i].press;
      fpmc_debounce #(.DEB_CYC_P(DEB_CYC_P)) u_deb (
         .clk    (MCLK),
         .arst_n (ARST_N),
         .sw     (sw_if[i].deb)
      );
   end

   assign m_ev    = press[SW_MENU];
   assign l_ev    = press[SW_LEFT];
   assign r_ev    = press[SW_RIGHT];
   assign u_ev    = press[SW_UP];
   assign d_ev    = press[SW_DOWN];
   assign vert_ev = u_ev | d_ev;
   assign any_ev  = |press;

   function automatic logic [2:0] r_pos(fpmc_menu_t m);
      case (m)
         MN_GAIN: r_pos = CUR_R_GAIN;
         MN_OFS:  r_pos = CUR_R_OFS;
         default: r_pos = CUR_R_FLAG;
      endcase
   endfunction

   // up raises gain, which lowers the attenuation
   function automatic logic [6:0] gain_step(logic [6:0] g, logic [2:0] c,
                                             logic up);
      logic [7:0] step;
      logic [7:0] v;
      case (c)
         3'h0:    step = STEP_10DB;
         3'h1:    step = STEP_1DB;
         default: step = STEP_HALF;
      endcase
      if (up) begin
         if ({1'b0, g} < {1'b0, GAIN_MIN_HDB} + step) begin
            v = {1'b0, GAIN_MIN_HDB};
         end else begin
            v = {1'b0, g} - step;
         end
      end else begin
         v = {1'b0, g} + step;
         if (v > {1'b0, GAIN_MAX_HDB}) begin
            v = {1'b0, GAIN_MAX_HDB};
         end
      end
      gain_step = v[6:0];
   endfunction

   function automatic logic [11:0] ofs_step(logic signed [11:0] o,
                                            logic [2:0] c, logic up);
      logic signed [12:0] step;
      logic signed [12:0] v;
      case (c)
         3'h0:    step = OFS_STEP_1000;
         3'h1:    step = OFS_STEP_100;
         3'h2:    step = OFS_STEP_10;
         default: step = OFS_STEP_1;
      endcase
      v = up ? 13'(o) + step : 13'(o) - step;
      if (v > OFS_LIM) begin
         v = OFS_LIM;
      end else if (v < -OFS_LIM) begin
         v = -OFS_LIM;
      end
      ofs_step = v[11:0];
   endfunction

   assign in_sess = (state_q == ST_EDIT) || (state_q == ST_SAVE);
   assign at_r    = (cur_q == r_pos(menu_q));
   assign on_val  = (state_q == ST_EDIT) && !at_r && vert_ev;
   assign confirm = (state_q == ST_SAVE) && m_ev && yes_q;

   // the gain menu is given the longer grace period
   assign idle_lim = (state_q == ST_EDIT && menu_q == MN_GAIN)
                     ? GIDLE_CYC_P : IDLE_CYC_P;
   assign tmo = in_sess && !any_ev && (idle_q >= idle_lim - 1);

   // edits act on the live outputs at once
   always_comb begin
      live_d = live_q;
      if (on_val) begin
         case (menu_q)
            MN_GAIN:   live_d.gain = gain_step(live_q.gain, cur_q, u_ev);
            MN_MUTE:   live_d.mute = ~live_q.mute;
            MN_REF: begin
               case (live_q.refsel)
                  REF_INT:  live_d.refsel = u_ev ? REF_EXT : REF_AUTO;
                  REF_EXT:  live_d.refsel = u_ev ? REF_AUTO : REF_INT;
                  default:  live_d.refsel = u_ev ? REF_INT : REF_EXT;
               endcase
            end
            MN_OFS:    live_d.ofs = ofs_step(live_q.ofs, cur_q, u_ev);
            MN_REMOTE: live_d.remote = ~live_q.remote;
            default:   live_d.comm = ~live_q.comm;
         endcase
      end
   end

   // stored image is used only when its gain and reference select hold legal values
   always_comb begin
      boot = SET_RST;
      if (NV_VALID) begin
         boot = fpmc_set_t'(NV_RD_DATA);
         if (boot.gain < GAIN_MIN_HDB || boot.gain > GAIN_MAX_HDB
             || boot.refsel == 2'h3) begin
            boot = SET_RST;
         end
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         load_q <= 1'b1;
      end else begin
         load_q <= 1'b0;
      end
   end

   // saved_q mirrors storage and doubles as the undo copy
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         live_q  <= SET_RST;
         saved_q <= SET_RST;
      end else if (load_q) begin
         live_q  <= boot;
         saved_q <= boot;
      end else if (tmo) begin
         live_q <= saved_q;
      end else if (state_q == ST_SAVE && m_ev) begin
         if (yes_q) begin
            saved_q <= live_q;
         end else begin
            live_q <= saved_q;
         end
      end else begin
         live_q <= live_d;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         nv_we_q <= 1'b0;
      end else begin
         nv_we_q <= confirm;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         idle_q <= '0;
      end else if (!in_sess || any_ev || tmo) begin
         idle_q <= '0;
      end else begin
         idle_q <= idle_q + 1'b1;
      end
   end

   assign phase_done = (phase_q == PHASE_CYC_P - 1);

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         phase_q <= '0;
      end else if (state_q != ST_LAMP && state_q != ST_VER) begin
         phase_q <= '0;
      end else if (phase_done) begin
         phase_q <= '0;
      end else begin
         phase_q <= phase_q + 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q <= ST_LAMP;
         menu_q  <= MN_GAIN;
         cur_q   <= 3'h0;
         yes_q   <= 1'b0;
      end else begin
         case (state_q)
            ST_LAMP: begin
               if (phase_done) state_q <= ST_VER;
            end
            ST_VER: begin
               if (phase_done) state_q <= ST_RUN;
            end
            ST_RUN: begin
               if (m_ev) begin
                  state_q <= ST_EDIT;
                  menu_q  <= MN_GAIN;
                  cur_q   <= 3'h0;
               end
            end
            ST_EDIT: begin
               if (tmo) begin
                  state_q <= ST_RUN;
               end else if (m_ev) begin
                  if (at_r || menu_q == MN_COMM) begin
                     state_q <= ST_SAVE;
                     yes_q   <= 1'b0;
                  end else begin
                     menu_q <= fpmc_menu_t'(menu_q + 3'h1);
                     cur_q  <= 3'h0;
                  end
               end else if (l_ev && cur_q != 3'h0) begin
                  cur_q <= cur_q - 3'h1;
               end else if (r_ev && !at_r) begin
                  cur_q <= cur_q + 3'h1;
               end
            end
            ST_SAVE: begin
               if (tmo || m_ev) begin
                  state_q <= ST_RUN;
               end else if (vert_ev || l_ev || r_ev) begin
                  yes_q <= ~yes_q;
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // lock detector is asynchronous to this clock
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         al1_q   <= 1'b0;
         al2_q   <= 1'b0;
         al3_q   <= 1'b0;
         alarm_q <= 1'b0;
      end else begin
         al1_q <= PLL_UNLOCK;
         al2_q <= al1_q;
         al3_q <= al2_q;
         if (al2_q == al3_q) alarm_q <= al3_q;
      end
   end

   assign NV_WE         = nv_we_q;
   assign NV_WR_DATA    = saved_q;
   assign GAIN_HDB      = live_q.gain;
   assign MUTE          = live_q.mute;
   assign REF_SEL       = live_q.refsel;
   assign REF_OFS       = live_q.ofs;
   assign REMOTE        = live_q.remote;
   assign COMM_SEL      = live_q.comm;
   assign ALARM         = alarm_q;
   assign LED_ALARM     = alarm_q;
   assign LED_MUTE      = live_q.mute;
   assign LED_REMOTE    = live_q.remote;
   assign DISP_STATE    = state_q;
   assign DISP_MENU     = menu_q;
   assign DISP_CURSOR   = cur_q;
   assign DISP_SAVE_YES = yes_q;
   assign DISP_VERSION  = VERSION_P;

   gain_range_a: assert property (@(posedge MCLK)
      GAIN_HDB >= GAIN_MIN_HDB && GAIN_HDB <= GAIN_MAX_HDB)
      else $error("gain outside allowed range");

   save_entry_a: assert property (@(posedge MCLK)
      state_q == ST_EDIT && m_ev && at_r |=> state_q == ST_SAVE && !yes_q)
      else $error("return item did not open save prompt");

   yes_store_a: assert property (@(posedge MCLK)
      confirm |=> NV_WE && NV_WR_DATA == $past(live_q) ##1 !NV_WE)
      else $error("confirmed save not written once");

   tmo_restore_a: assert property (@(posedge MCLK)
      tmo |=> state_q == ST_RUN && live_q == $past(saved_q))
      else $error("timeout did not restore settings");

   idle_bound_a: assert property (@(posedge MCLK)
      any_ev |=> idle_q == 32'h0)
      else $error("idle timer not restarted by switch event");

   no_restore_a: assert property (@(posedge MCLK)
      state_q == ST_SAVE && m_ev && !yes_q |=> live_q == $past(saved_q)
      && !NV_WE)
      else $error("no answer did not restore settings");

   mute_led_a: assert property (@(posedge MCLK)
      on_val && menu_q == MN_MUTE && !tmo |=> LED_MUTE != $past(LED_MUTE))
      else $error("mute did not toggle");

   half_step_a: assert property (@(posedge MCLK)
      on_val && menu_q == MN_GAIN && cur_q == 3'h2 && d_ev && !u_ev
      && GAIN_HDB < GAIN_MAX_HDB |=> GAIN_HDB == $past(GAIN_HDB) + 7'h01)
      else $error("half dB step wrong");

   menu_next_a: assert property (@(posedge MCLK)
      state_q == ST_EDIT && m_ev && !at_r && menu_q != MN_COMM
      |=> menu_q == fpmc_menu_t'($past(menu_q) + 3'h1) && cur_q == 3'h0)
      else $error("menu press did not advance");

   power_seq_a: assert property (@(posedge MCLK)
      state_q == ST_LAMP && phase_done |=> state_q == ST_VER)
      else $error("lamp test not followed by version");

   alarm_a: assert property (@(posedge MCLK)
      PLL_UNLOCK [*4] |=> LED_ALARM && ALARM)
      else $error("alarm not raised on lock loss");
endmodule

// ---- test/fpmc_operator.sv ----
// Operator and settings storage model facing the menu controller.
`timescale 1ns/100ps
module fpmc_operator
   import fpmc_pkg::*;
#(
   parameter int unsigned HOLD_CYC = 10,
   parameter fpmc_set_t   IMG0     = SET_RST
) (
   input  wire logic             clk,
   input  wire logic             nv_we,
   input  wire logic [SET_W-1:0] nv_wr_data,
   output logic                  nv_valid,
   output logic [SET_W-1:0]      nv_rd_data,
   output logic [SW_N-1:0]       sw_n
);
   initial begin
      sw_n       = '1;
      nv_valid   = 1'b1;
      nv_rd_data = IMG0;
   end

   // storage keeps its image while the controller is held in reset
   always @(posedge clk) begin
      if (nv_we === 1'b1) begin
         nv_rd_data <= nv_wr_data;
      end
   end

   // hold and release both outlast the debounce, so one press is one event
   task automatic press(input int k);
      @(posedge clk);
      sw_n[k] <= 1'b0;
      repeat (HOLD_CYC) @(posedge clk);
      sw_n[k] <= 1'b1;
      repeat (HOLD_CYC) @(posedge clk);
   endtask
endmodule

// ---- test/fpmc_top_tb.sv ----
// Self-checking bench for the front panel menu controller.
`timescale 1ns/100ps
module fpmc_top_tb;
   import fpmc_pkg::*;
   localparam fpmc_set_t IMG0 = '{gain: 7'h30, mute: 1'b1,
      refsel: REF_EXT, ofs: 12'h000, remote: 1'b1, comm: 1'b0};
   localparam fpmc_set_t IMG1 = '{gain: 7'h30, mute: 1'b0,
      refsel: REF_EXT, ofs: 12'h3E8, remote: 1'b0, comm: 1'b1};
   localparam logic [15:0] VER = 16'h0100; // value is arbitrary

   logic             mclk;
   logic             arst_n;
   logic             pll_unlock;
   logic [SW_N-1:0]  sw_n;
   logic             nv_valid;
   logic [SET_W-1:0] nv_rd_data;
   logic             nv_we;
   logic [SET_W-1:0] nv_wr_data;
   logic [6:0]       gain_hdb;
   logic             mute;
   logic [1:0]       ref_sel;
   logic [11:0]      ref_ofs;
   logic             remote;
   logic             comm_sel;
   logic             alarm;
   logic             led_alarm;
   logic             led_mute;
   logic             led_remote;
   logic [2:0]       disp_state;
   logic [2:0]       disp_menu;
   logic [2:0]       disp_cursor;
   logic             disp_save_yes;
   logic [15:0]      disp_version;
   logic [SET_W-1:0] live;
   int               n_fail;
   int               comparisons;
   int               nv_writes;
   fpmc_ref_t        ring [3] = '{REF_AUTO, REF_INT, REF_EXT};

   assign live = {gain_hdb, mute, ref_sel, ref_ofs, remote, comm_sel};

   fpmc_top #(.DEB_CYC_P(4), .PHASE_CYC_P(8), .IDLE_CYC_P(50),
      .GIDLE_CYC_P(120), .VERSION_P(VER)) i_fpmc_top (
      .MCLK(mclk), .ARST_N(arst_n),
      .MENU_SW_N(sw_n[SW_MENU]), .LEFT_SW_N(sw_n[SW_LEFT]),
      .RIGHT_SW_N(sw_n[SW_RIGHT]), .UP_SW_N(sw_n[SW_UP]),
      .DOWN_SW_N(sw_n[SW_DOWN]), .PLL_UNLOCK(pll_unlock),
      .NV_VALID(nv_valid), .NV_RD_DATA(nv_rd_data), .NV_WE(nv_we),
      .NV_WR_DATA(nv_wr_data), .GAIN_HDB(gain_hdb), .MUTE(mute),
      .REF_SEL(ref_sel), .REF_OFS(ref_ofs), .REMOTE(remote),
      .COMM_SEL(comm_sel), .ALARM(alarm), .LED_ALARM(led_alarm),
      .LED_MUTE(led_mute), .LED_REMOTE(led_remote),
      .DISP_STATE(disp_state), .DISP_MENU(disp_menu),
      .DISP_CURSOR(disp_cursor), .DISP_SAVE_YES(disp_save_yes),
      .DISP_VERSION(disp_version));

   fpmc_operator #(.HOLD_CYC(10), .IMG0(IMG0)) i_fpmc_operator (
      .clk(mclk), .nv_we(nv_we), .nv_wr_data(nv_wr_data),
      .nv_valid(nv_valid), .nv_rd_data(nv_rd_data), .sw_n(sw_n));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial begin
      arst_n      = 1'b0;
      pll_unlock  = 1'b0;
      n_fail      = 0;
      comparisons = 0;
      nv_writes   = 0;
   end

   always @(posedge mclk) begin
      if (nv_we === 1'b1) begin
         nv_writes++;
      end
   end

   task automatic give_verdict();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp,
      input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what,
            seen, exp);
      end
   endtask

   task automatic wait_state(input logic [2:0] v, input int lim);
      int i;
      i = 0;
      while (disp_state !== v && i < lim) begin
         @(posedge mclk);
         i++;
      end
      check(disp_state, v, "display state");
      if (disp_state !== v) begin
         give_verdict();
      end
   endtask

   task automatic do_reset();
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
   endtask

   task automatic pr(input int k);
      i_fpmc_operator.press(k);
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      give_verdict();
   end

   initial begin
      do_reset();
      repeat (2) @(posedge mclk);
      check(disp_state, 3'h0, "lamp test");
      wait_state(3'h1, 20);
      check(disp_version, VER, "version");
      wait_state(3'h2, 20);
      check(live, IMG0, "restored settings");
      check({led_mute, led_remote}, 2'h3, "leds");
      // edit gain then answer no
      pr(SW_MENU);
      check(disp_state, 3'h3, "edit");
      check(disp_menu, 3'h0, "first menu");
      pr(SW_UP);
      check(gain_hdb, GAIN_MIN_HDB, "gain clamp");
      pr(SW_RIGHT);
      check(disp_cursor, 3'h1, "cursor right");
      pr(SW_DOWN);
      check(gain_hdb, 7'h2A, "gain 1 dB");
      pr(SW_RIGHT);
      pr(SW_DOWN);
      check(gain_hdb, 7'h2B, "gain half dB");
      pr(SW_LEFT);
      check(disp_cursor, 3'h1, "cursor left");
      pr(SW_UP);
      check(gain_hdb, 7'h29, "gain up");
      repeat (3) pr(SW_RIGHT);
      check(disp_cursor, CUR_R_GAIN, "cursor at R");
      pr(SW_UP);
      check(gain_hdb, 7'h29, "gain applied");
      pr(SW_MENU);
      check({disp_state, disp_save_yes}, 4'h8, "save");
      pr(SW_MENU);
      check(live, IMG0, "answer no");
      check(nv_writes, 0, "no store");
      // walk every menu and store
      pr(SW_MENU);
      pr(SW_MENU);
      check(disp_menu, 3'h1, "mute menu");
      pr(SW_UP);
      check({mute, led_mute}, 2'h0, "mute off");
      pr(SW_DOWN);
      check(mute, 1'b1, "mute toggle");
      pr(SW_UP);
      pr(SW_MENU);
      check(disp_menu, 3'h2, "ref menu");
      for (int i = 0; i < 3; i++) begin
         pr(SW_UP);
         check(ref_sel, ring[i], "ref up");
      end
      pr(SW_DOWN);
      check(ref_sel, REF_INT, "ref down");
      pr(SW_UP);
      pr(SW_MENU);
      pr(SW_UP);
      check(ref_ofs, 12'h3E8, "offset");
      pr(SW_UP);
      pr(SW_UP);
      check(ref_ofs, 12'h7D0, "offset clamp");
      pr(SW_DOWN);
      check(ref_ofs, 12'h3E8, "offset down");
      pr(SW_MENU);
      pr(SW_UP);
      check({remote, led_remote}, 2'h0, "remote");
      pr(SW_MENU);
      check({disp_state, disp_menu}, 6'h1D, "comm");
      pr(SW_DOWN);
      check(comm_sel, 1'b1, "comm toggle");
      pr(SW_MENU);
      check(disp_state, 3'h4, "save at end");
      pr(SW_LEFT);
      check(disp_save_yes, 1'b1, "yes");
      pr(SW_MENU);
      check(nv_writes, 1, "one store");
      check(nv_wr_data, IMG1, "stored image");
      check(live, IMG1, "live kept");
      // idle abandon outside and inside the gain menu
      pr(SW_MENU);
      pr(SW_MENU);
      pr(SW_UP);
      check(mute, 1'b1, "mute edit");
      wait_state(3'h2, 100);
      check(live, IMG1, "idle restore");
      pr(SW_MENU);
      pr(SW_UP);
      repeat (60) @(posedge mclk);
      check(disp_state, 3'h3, "gain still edit");
      wait_state(3'h2, 150);
      check(live, IMG1, "gain restore");
      // oscillator lock loss
      pll_unlock <= 1'b1;
      repeat (6) @(posedge mclk);
      check({alarm, led_alarm}, 2'h3, "alarm on");
      pll_unlock <= 1'b0;
      repeat (6) @(posedge mclk);
      check({alarm, led_alarm}, 2'h0, "alarm off");
      // power cycle reloads the stored image
      do_reset();
      wait_state(3'h2, 40);
      check(live, IMG1, "reload");
      give_verdict();
   end
endmodule
